// ---- core/ppm_cap_regs.v ----
// PM capability, link status two and reserved slot registers of a port
//
// What this block does
// - At 5.0 Gbps the de-emphasis bit reads 0 for -6.0 dB, 1 for -3.5 dB.
// - At 2.5 Gbps the de-emphasis bit has no meaning and may read anything.
// - Slot capabilities, control and status two are reserved and read zero.
// - The low byte of the PM capabilities register reads identifier 0x1.
// - Next pointer resets to 0x0 on the upstream port, 0xD0 downstream.
// - The PM version field reads 0x3.
// - PME clock, aux current and bit 20 read zero.
// - The device specific init bit resets to zero.
// - D1 and D2 support bits read zero.
// - PME support resets to 0b11001.
// - No PME message is forwarded while in D3cold.
// - A write to PME support changes only the read-back value.
// - The structure at 0xD0 reads capability identifier 0x5.
`timescale 1ns/1ns
`include "ppm_regs.vh"

module ppm_cap_regs #(
    parameter ADDR_W = 12
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire upstream_strap,
    input wire link_speed_5g,
    input wire tx_deemph_3p5db,
    input wire [1:0] power_state,
    input wire d3cold_active,
    input wire pme_msg_in,
    output reg pme_msg_fwd,
    output reg pme_msg_drop
);

    // Strap synchroniser and one-shot capture after reset release
    reg strap_meta_reg;
    reg strap_sync_reg;
    reg strap_done_reg;

    // Software visible lockable fields
    reg [7:0] next_capability_pointer_reg;
    reg dsi_reg;
    reg [4:0] pme_adv_reg;

    // Link status sampling
    reg deemph_reg;

    // Decoded accesses
    wire hit_pm_cap;
    wire wr_pm_cap;
    reg [31:0] rd_next;

    // Two flip-flops for the strap pin, left running through reset
    // so that the synchronised role is valid at the first capture
    always @(posedge sys_clk) begin
        strap_meta_reg <= upstream_strap;
        strap_sync_reg <= strap_meta_reg;
    end

    // Port role caught once, first edge after release
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
        end
    end

    assign hit_pm_cap = (reg_addr == `PPM_OFS_PM_CAP);
    assign wr_pm_cap = reg_wr && hit_pm_cap;

    // Lockable fields: next pointer takes its role default at capture
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            next_capability_pointer_reg <= `PPM_NEXT_CAPABILITY_POINTER_DN;
            dsi_reg <= `PPM_DSI_RESET;
            pme_adv_reg <= `PPM_PME_SUPPORT_RESET;
        end else if (!strap_done_reg) begin
            // Role default replaces any earlier write
            next_capability_pointer_reg <= strap_sync_reg ? `PPM_NEXT_CAPABILITY_POINTER_UP
                                         : `PPM_NEXT_CAPABILITY_POINTER_DN;
        end else if (wr_pm_cap) begin
            next_capability_pointer_reg <= reg_wdata[`PPM_PMC_NEXT_CAPABILITY_POINTER_LSB +: 8];
            dsi_reg <= reg_wdata[`PPM_PMC_DSI_BIT];
            // Read-back only, forwarding ignores it
            pme_adv_reg <= reg_wdata[`PPM_PMC_PME_LSB +: 5];
        end
    end

    // Current de-emphasis follows the transmitter at 5.0 Gbps
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            deemph_reg <= 1'b0;
        end else if (link_speed_5g) begin
            deemph_reg <= tx_deemph_3p5db;
        end else begin
            // Held value at 2.5 Gbps, no meaning
            deemph_reg <= deemph_reg;
        end
    end

    // Read mux; all other bits and addresses read zero
    always @* begin
        rd_next = 32'h0000_0000;
        case (reg_addr)
            `PPM_OFS_LINK_STATUS_TWO: begin
                rd_next[`PPM_LS2_DEEMPH_BIT] = deemph_reg;
            end
            `PPM_OFS_SLOT_CAP_TWO,
            `PPM_OFS_SLOT_CTL_TWO,
            `PPM_OFS_SLOT_STS_TWO: begin
                rd_next = 32'h0000_0000;
            end
            `PPM_OFS_PM_CAP: begin
                rd_next[`PPM_PMC_CAPABILITY_IDENTIFIER_LSB +: 8] = `PPM_CAPABILITY_IDENTIFIER_PM;
                rd_next[`PPM_PMC_NEXT_CAPABILITY_POINTER_LSB +: 8] = next_capability_pointer_reg;
                rd_next[`PPM_PMC_VER_LSB +: 3] = `PPM_PM_VERSION;
                rd_next[`PPM_PMC_CLK_BIT] = 1'b0;
                rd_next[`PPM_PMC_RSVD_BIT] = 1'b0;
                rd_next[`PPM_PMC_DSI_BIT] = dsi_reg;
                rd_next[`PPM_PMC_AUX_LSB +: 3] = 3'h0;
                rd_next[`PPM_PMC_D1_BIT] = 1'b0;
                rd_next[`PPM_PMC_D2_BIT] = 1'b0;
                rd_next[`PPM_PMC_PME_LSB +: 5] = pme_adv_reg;
            end
            `PPM_OFS_MSI_CAP: begin
                rd_next[7:0] = `PPM_CAPABILITY_IDENTIFIER_MSI;
                rd_next[15:8] = `PPM_NEXT_CAPABILITY_POINTER_MSI;
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_next;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Forwarding follows the reset support mask, never the written one
    wire [4:0] fwd_mask;
    reg state_ok;
    assign fwd_mask = `PPM_PME_SUPPORT_RESET;

    always @* begin
        case (power_state)
            `PPM_PSTATE_D0: state_ok = fwd_mask[0];
            `PPM_PSTATE_D1: state_ok = fwd_mask[1];
            `PPM_PSTATE_D2: state_ok = fwd_mask[2];
            `PPM_PSTATE_D3HOT: state_ok = fwd_mask[3];
            default: state_ok = 1'b0;
        endcase
    end

    // One-cycle forward or drop pulse per incoming PME message
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pme_msg_fwd <= 1'b0;
            pme_msg_drop <= 1'b0;
        end else begin
            pme_msg_fwd <= pme_msg_in && state_ok
                           && !d3cold_active;
            pme_msg_drop <= pme_msg_in
                            && (!state_ok || d3cold_active);
        end
    end

endmodule

// ---- core/ppm_regs.vh ----
// Offsets, field positions and reset values of the PM capability slice
`ifndef PPM_REGS_VH
`define PPM_REGS_VH

// Byte offsets as printed in configuration space
`define PPM_OFS_LINK_STATUS_TWO 12'h072
`define PPM_OFS_SLOT_CAP_TWO 12'h074
`define PPM_OFS_SLOT_CTL_TWO 12'h078
`define PPM_OFS_SLOT_STS_TWO 12'h07A
`define PPM_OFS_PM_CAP 12'h0C0
`define PPM_OFS_MSI_CAP 12'h0D0

// Link status two fields
`define PPM_LS2_DEEMPH_BIT 0

// Power management capabilities fields
`define PPM_PMC_CAPABILITY_IDENTIFIER_LSB 0
`define PPM_PMC_NEXT_CAPABILITY_POINTER_LSB 8
`define PPM_PMC_VER_LSB 16
`define PPM_PMC_CLK_BIT 19
`define PPM_PMC_RSVD_BIT 20
`define PPM_PMC_DSI_BIT 21
`define PPM_PMC_AUX_LSB 22
`define PPM_PMC_D1_BIT 25
`define PPM_PMC_D2_BIT 26
`define PPM_PMC_PME_LSB 27

// Fixed and reset values
`define PPM_CAPABILITY_IDENTIFIER_PM 8'h01
`define PPM_CAPABILITY_IDENTIFIER_MSI 8'h05
`define PPM_NEXT_CAPABILITY_POINTER_UP 8'h00
`define PPM_NEXT_CAPABILITY_POINTER_DN 8'hD0
`define PPM_NEXT_CAPABILITY_POINTER_MSI 8'h00
`define PPM_PM_VERSION 3'h3
`define PPM_DSI_RESET 1'h0
`define PPM_PME_SUPPORT_RESET 5'h19

// Power state codes
`define PPM_PSTATE_D0 2'h0
`define PPM_PSTATE_D1 2'h1
`define PPM_PSTATE_D2 2'h2
`define PPM_PSTATE_D3HOT 2'h3

`endif

// ---- dv/ppm_cap_regs_chk.sv ----
// Port assertions for the PM capability register slice
`timescale 1ns/1ns
module ppm_cap_regs_chk #(parameter ADDR_W = 12) (
    input wire sys_clk,
    input wire rst_n,
    input wire [ADDR_W-1:0] reg_addr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire link_speed_5g,
    input wire tx_deemph_3p5db,
    input wire [1:0] power_state,
    input wire d3cold_active,
    input wire pme_msg_in,
    input wire pme_msg_fwd,
    input wire pme_msg_drop
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Read decodes and the power states that forward
    wire rd_pm = reg_rd && reg_addr == 12'h0C0;
    wire rd_ls = reg_rd && reg_addr == 12'h072 && link_speed_5g;
    wire rd_rs = reg_rd && (reg_addr == 12'h074 || reg_addr == 12'h078
        || reg_addr == 12'h07A);
    wire ps_ok = power_state == 2'h0 || power_state == 2'h3;
    // Fixed fields and reserved places
    property p_id; rd_pm |=> reg_rdata[7:0] == 8'h01; endproperty
    a_id: assert property (p_id) else $error("bad cap id");
    property p_ver; rd_pm |=> reg_rdata[20:16] == 5'h03; endproperty
    a_ver: assert property (p_ver) else $error("bad version");
    property p_zro; rd_pm |=> reg_rdata[26:22] == 5'h00; endproperty
    a_zro: assert property (p_zro) else $error("bad zero bits");
    property p_rsv; rd_rs |=> reg_rdata == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved not 0");
    property p_msi; reg_rd && reg_addr == 12'h0D0 |=> reg_rdata[7:0] == 8'h05;
    endproperty
    a_msi: assert property (p_msi) else $error("bad msi id");
    // De-emphasis level at 5.0 Gbps
    property p_cde; rd_ls && $past(link_speed_5g) && $stable(tx_deemph_3p5db)
        |=> reg_rdata == {31'h0, $past(tx_deemph_3p5db)}; endproperty
    a_cde: assert property (p_cde) else $error("bad de-emphasis");
    // PME forwarding follows the default state set
    property p_cold; pme_msg_in && d3cold_active
        |=> pme_msg_drop && !pme_msg_fwd; endproperty
    a_cold: assert property (p_cold) else $error("pme in d3cold");
    property p_fwd; pme_msg_in && !d3cold_active
        |=> pme_msg_fwd == $past(ps_ok) && pme_msg_drop != pme_msg_fwd;
    endproperty
    a_fwd: assert property (p_fwd) else $error("bad pme route");
endmodule
bind ppm_cap_regs ppm_cap_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- dv/tb_ppm_cap_regs.sv ----
// Directed register and PME tests of the PM capability slice
`timescale 1ns/1ns
module tb_ppm_cap_regs;
    reg sys_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    reg up = 1'h0, l5 = 1'h0, tx = 1'h0, cold = 1'h0, pin = 1'h0;
    reg [11:0] addr = 12'h0;
    reg [31:0] wdata = 32'h0;
    reg [1:0] ps = 2'h0;
    wire [31:0] rdata;
    wire fwd, drop;
    wire [59:0] rs = {12'h100, 12'h07A, 12'h078, 12'h074, 12'h072};
    integer n_mismatch = 0, checks_done = 0, cyc = 0, i;
    ppm_cap_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .upstream_strap(up), .link_speed_5g(l5),
        .tx_deemph_3p5db(tx), .power_state(ps), .d3cold_active(cold),
        .pme_msg_in(pin), .pme_msg_fwd(fwd), .pme_msg_drop(drop));
    initial forever #20 sys_clk = ~sys_clk;
    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    end
    task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // One register access; a read compares against d
    task acc(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            addr <= a;
            wdata <= d;
            reg_wr <= w;
            reg_rd <= !w;
            @(posedge sys_clk);
            reg_wr <= 1'h0;
            reg_rd <= 1'h0;
            #1 if (!w) chk("reg", rdata, d);
        end
    endtask
    // One PME message; forwarded only in D0 or D3hot outside D3cold
    task pme(input [1:0] s, input c);
        begin
            @(posedge sys_clk);
            ps <= s;
            cold <= c;
            pin <= 1'h1;
            @(posedge sys_clk);
            pin <= 1'h0;
            #1 chk("pme", {drop, fwd}, (!c && (s == 0 || s == 3)) ? 1 : 2);
        end
    endtask
    task rst(input u);
        begin
            @(posedge sys_clk);
            up <= u;
            rst_n <= 1'h0;
            repeat (16) @(posedge sys_clk);
            rst_n <= 1'h1;
            repeat (3) @(posedge sys_clk);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        rst(1'h0);
        acc(1'h0, 12'h0C0, 32'hC803D001);
        acc(1'h0, 12'h0D0, 32'h00000005);
        for (i = 0; i < 5; i = i + 1) begin
            acc(1'h1, rs[i*12 +: 12], 32'hFFFFFFFF);
            acc(1'h0, rs[i*12 +: 12], 32'h0);
        end
        acc(1'h1, 12'h0C0, 32'hFFFFFFFF);
        acc(1'h0, 12'h0C0, 32'hF823FF01);
        for (i = 0; i < 8; i = i + 1)
            pme(i[1:0], i[2]);
        @(posedge sys_clk);
        l5 <= 1'h1;
        tx <= 1'h1;
        acc(1'h0, 12'h072, 32'h1);
        @(posedge sys_clk);
        tx <= 1'h0;
        acc(1'h0, 12'h072, 32'h0);
        rst(1'h1);
        acc(1'h0, 12'h0C0, 32'hC8030001);
        close_out;
    end
endmodule
